// ---- rtl/pclr_dev.sv ----
// Device end of the fast parallel load port, ratio of clocks per word of one, two, four or eight.
// Assumes link pins arrive asynchronously and the link clock is much slower than sys_clk.
// Operation
// RULE1: Idle all high; request low restarts load
// RULE2: Status held low through power-on delay
// RULE3: Done low from power-up until image complete
// RULE4: Host pauses clock low, data before rise
// RULE5: Whole image sent; done rises after it
// RULE6: Host gives two falls after done
// RULE7: Init pin low once enabled until finished
// RULE8: Done low within 600 ns of request
// RULE9: Status low within 600 ns of request
// RULE10: Host holds request low two microseconds
// RULE11: Status low 268 to 1506 microseconds
// RULE12: Status released within 1506 after request
// RULE13: Unwatching host waits 1506 before clocking
// RULE14: Watching host waits 2 after status
// RULE15: Host holds each word ratio periods
// RULE16: Internal init takes 175 to 437 microseconds
// RULE17: User clock taken four periods after done
// RULE18: User clock runs 8576 cycles to finish
// RULE19: Narrow widths use only low lanes
// RULE20: Ratio timing when compression or security
// RULE21: Host clock is ratio times word rate
// RULE22: Host clocks ratio-1 more after last
// RULE23: Status low while loading means restart
`timescale 1ns/1ps
`default_nettype none
module pclr_dev
  import pclr_pkg::*;
#(
  // Long waits, shortened in simulation
  parameter int POR_CYC = POR_DEFAULT_CYC,
  parameter int ST_MIN_CYC = (T_STATUS_MIN_US * 1000 + CLK_NS - 1) / CLK_NS,
  parameter int CD2UM_CYC = (T_CD2UM_MIN_US * 1000 + CLK_NS - 1) / CLK_NS,
  parameter int UCK_INIT_CYC = UCK_INIT_EDGES
) (
  // System
  input wire logic sys_clk,
  input wire logic reset,
  // Link
  pclr_if.dev lnk,
  // Initialization clock from the user
  input wire logic user_init_clock,
  // Bus width strap
  input wire logic [1:0] scheme_select,
  // Image length in beats, header included
  input wire logic [CW-1:0] img_beats,
  // Received beats
  output logic [31:0] word_out,
  output logic word_valid,
  // Load finished
  output logic user_mode
);

  // Registered state and its next value
  pclr_dq_t q_q;
  pclr_dq_t q_d;
  // Link clock edges seen this cycle
  logic rise;
  logic fall;
  // User clock rising edge
  logic urise;
  // Request falling edge
  logic req_fall;
  // Beat and phase after this edge
  logic [CW-1:0] nbt;
  logic [2:0] nph;

  // Next state
  always_comb begin
    q_d = q_q;
    // Two-flop synchronisers for every pin
    q_d.req_s1 = lnk.cfg_req_n;
    q_d.req_s2 = q_q.req_s1;
    q_d.clk_s1 = lnk.cfg_clock;
    q_d.clk_s2 = q_q.clk_s1;
    q_d.st_s1 = lnk.status_n;
    q_d.st_s2 = q_q.st_s1;
    q_d.uck_s1 = user_init_clock;
    q_d.uck_s2 = q_q.uck_s1;
    q_d.sel_s1 = scheme_select;
    q_d.sel_s2 = q_q.sel_s1;
    // Data shares the clock's sync depth so they stay aligned
    q_d.dat_s1 = lnk.data;
    q_d.dat_s2 = q_q.dat_s1;
    // Edge detect delays
    q_d.req_d = q_q.req_s2;
    q_d.clk_d = q_q.clk_s2;
    q_d.uck_d = q_q.uck_s2;
    rise = q_q.clk_s2 & ~q_q.clk_d;
    fall = ~q_q.clk_s2 & q_q.clk_d;
    urise = q_q.uck_s2 & ~q_q.uck_d;
    req_fall = ~q_q.req_s2 & q_q.req_d;
    nbt = q_q.bt;
    nph = q_q.ph;
    // Beat strobe lasts one cycle
    q_d.word_vld = 1'b0;

    case (q_q.st)
      // Power-on wait, status and done held low
      D_POR: begin
        if (q_q.cnt != CW'(POR_CYC - 1)) begin
          q_d.cnt = q_q.cnt + 1'b1; // [RULE2]
        end else if (q_q.req_s2) begin
          // Request low here simply extends the wait
          q_d.st = D_REL;
          q_d.st_oe_n = 1'b1;
          q_d.cnt = '0;
        end
      end
      // Reconfiguration reset pulse on the status line
      D_RST: begin
        if (q_q.cnt != CW'(ST_MIN_CYC - 1)) begin
          q_d.cnt = q_q.cnt + 1'b1; // [RULE11]
        end else if (q_q.req_s2) begin
          // Released as soon as the minimum has passed and request is high
          q_d.st = D_REL; // [RULE12]
          q_d.st_oe_n = 1'b1;
          q_d.cnt = '0;
        end
      end
      // Released; an outside driver may still hold status low
      D_REL: begin
        if (q_q.st_s2) begin
          q_d.st = D_LOAD;
          q_d.bt = '0;
          q_d.ph = '0;
        end
      end
      // Taking beats on link clock rising edges
      D_LOAD: begin
        if (rise) begin
          if (q_q.ph == 3'h0) begin
            // Only the lanes of the chosen width carry data
            q_d.word = bus_mask(q_q.sel_s2, q_q.dat_s2); // [RULE19]
            q_d.word_vld = 1'b1;
            nbt = q_q.bt + 1'b1;
            nph = q_q.ph;
            if (q_q.bt == '0) begin
              // Header beat sets the options and the ratio at once
              q_d.opt_init = q_q.dat_s2[HDR_INIT_BIT];
              q_d.opt_uck = q_q.dat_s2[HDR_UCK_BIT];
              q_d.opt_cmp = q_q.dat_s2[HDR_CMP_BIT];
              q_d.opt_sec = q_q.dat_s2[HDR_SEC_BIT];
              nph = ratio_m1(q_q.sel_s2, q_q.dat_s2[HDR_CMP_BIT], q_q.dat_s2[HDR_SEC_BIT]); // [RULE20]
              q_d.init_oe_n = ~q_q.dat_s2[HDR_INIT_BIT]; // [RULE7]
            end else begin
              // Later beats keep the ratio the header declared
              nph = ratio_m1(q_q.sel_s2, q_q.opt_cmp, q_q.opt_sec); // [RULE20]
            end
          end else begin
            // Spare clocks spent on decoding the word
            nph = q_q.ph - 3'h1;
          end
          q_d.bt = nbt;
          q_d.ph = nph;
          // Done only after the last beat and its spare clocks
          if (nbt == img_beats && nph == 3'h0) begin
            q_d.st = D_DONE;
            q_d.done_oe_n = 1'b1; // [RULE5] [RULE3]
            q_d.cnt = '0;
          end
        end
      end
      // Wait for two falling edges after done
      D_DONE: begin
        if (fall) begin
          if (q_q.cnt[0]) begin
            q_d.st = D_INIT;
            q_d.cnt = '0;
            q_d.sw = 1'b0;
          end else begin
            q_d.cnt = CW'(1);
          end
        end
      end
      // Initialization on the internal or the user clock
      D_INIT: begin
        if (!q_q.opt_uck) begin
          q_d.cnt = q_q.cnt + 1'b1;
          if (q_q.cnt == CW'(CD2UM_CYC - 1)) begin
            q_d.st = D_USER; // [RULE16]
          end
        end else if (!q_q.sw) begin
          // Hold off before switching to the user clock
          q_d.cnt = q_q.cnt + 1'b1;
          if (q_q.cnt == CW'(CD2CU_CYC - 1)) begin
            q_d.sw = 1'b1; // [RULE17]
            q_d.cnt = '0;
          end
        end else if (urise) begin
          // Stalls if the user clock stops
          q_d.cnt = q_q.cnt + 1'b1;
          if (q_q.cnt == CW'(UCK_INIT_CYC - 1)) begin
            q_d.st = D_USER; // [RULE18]
          end
        end
      end
      // Running; init pin released
      D_USER: begin
        q_d.init_oe_n = 1'b1;
        q_d.user_mode = 1'b1;
      end
      // Unused codes fall back to reset
      default: begin
        q_d = DEV_RST;
      end
    endcase

    // A falling request restarts from any state but power-on
    if (req_fall && q_q.st != D_POR) begin
      q_d.st = D_RST; // [RULE1]
      q_d.cnt = '0;
      // Both lines low a few cycles after the fall, well inside 600 ns
      q_d.st_oe_n = 1'b0; // [RULE9]
      q_d.done_oe_n = 1'b0; // [RULE8] [RULE3]
      q_d.init_oe_n = 1'b1;
      q_d.user_mode = 1'b0;
      q_d.opt_init = 1'b0;
      q_d.opt_uck = 1'b0;
      q_d.opt_cmp = 1'b0;
      q_d.opt_sec = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q_q <= DEV_RST;
    end else begin
      q_q <= q_d;
    end
  end

  // Open-drain drivers, all from flops
  assign lnk.st_out = q_q.st_out;
  assign lnk.st_oe_n = q_q.st_oe_n;
  assign lnk.done_out = q_q.done_out;
  assign lnk.done_oe_n = q_q.done_oe_n;
  assign lnk.init_out = q_q.init_out;
  assign lnk.init_oe_n = q_q.init_oe_n;
  // User side
  assign word_out = q_q.word;
  assign word_valid = q_q.word_vld;
  assign user_mode = q_q.user_mode;

endmodule
`default_nettype wire

// ---- rtl/pclr_pkg.sv ----
// Shared constants, types and decoders for the parallel config load link.
// Assumes a 50 MHz system clock on both ends; link pins are resolved in pclr_if.
package pclr_pkg;

  // System clock period
  localparam int CLK_NS = 20;
  // Width of every long counter
  localparam int CW = 20;

  // Bus width codes on scheme_select
  localparam logic [1:0] W8 = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W32 = 2'h2;

  // Option bits in the first (header) beat of an image
  localparam int HDR_CMP_BIT = 0;
  localparam int HDR_SEC_BIT = 1;
  localparam int HDR_INIT_BIT = 2;
  localparam int HDR_UCK_BIT = 3;

  // Clocks per data word
  localparam int RATIO_SEC32 = 4;
  localparam int RATIO_CMP32 = 8;
  localparam int RATIO_NARROW = 2;

  // Link timing as printed, then in system clocks
  localparam int T_CF2ST0_NS = 600;
  localparam int CF2ST0_CYC = T_CF2ST0_NS / CLK_NS;
  localparam int T_CF2CD_NS = 600;
  localparam int CF2CD_CYC = T_CF2CD_NS / CLK_NS;
  localparam int T_CFG_US = 2;
  localparam int CFG_CYC = (T_CFG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int T_ST2CK_US = 2;
  localparam int ST2CK_CYC = (T_ST2CK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int T_STATUS_MIN_US = 268;
  localparam int T_STATUS_MAX_US = 1506;
  localparam int T_CD2UM_MIN_US = 175;
  localparam int T_CD2UM_MAX_US = 437;
  localparam int POR_DEFAULT_CYC = 1000;
  // Four slowest link clock periods of 10 ns before the user clock is taken
  localparam int T_LINK_MAX_PER_NS = 10;
  localparam int T_CD2CU_NS = 4 * T_LINK_MAX_PER_NS;
  localparam int CD2CU_CYC = (T_CD2CU_NS + CLK_NS - 1) / CLK_NS;
  localparam int UCK_INIT_EDGES = 8576;
  // Host link clock half period in system clocks
  localparam int CK_HALF_CYC = 4;

  // Device states
  typedef enum logic [2:0] {
    D_POR = 3'h0, D_RST = 3'h1, D_REL = 3'h2, D_LOAD = 3'h3,
    D_DONE = 3'h4, D_INIT = 3'h5, D_USER = 3'h6
  } pclr_dst_t;

  // Host states
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_PULSE = 3'h1, H_WREL = 3'h2, H_GAP = 3'h3,
    H_SEND = 3'h4, H_TAIL = 3'h5
  } pclr_hst_t;

  // Whole state of the device end
  typedef struct packed {
    pclr_dst_t st;
    logic req_s1, req_s2, req_d;
    logic clk_s1, clk_s2, clk_d;
    logic st_s1, st_s2;
    logic uck_s1, uck_s2, uck_d;
    logic [1:0] sel_s1, sel_s2;
    logic [31:0] dat_s1, dat_s2;
    logic [CW-1:0] cnt, bt;
    logic [2:0] ph;
    logic opt_init, opt_uck, sw;
    // Header compression and security bits, kept for the later beats
    logic opt_cmp, opt_sec;
    logic st_out, st_oe_n, done_out, done_oe_n, init_out, init_oe_n;
    logic [31:0] word;
    logic word_vld, user_mode;
  } pclr_dq_t;

  // Whole state of the host end
  typedef struct packed {
    pclr_hst_t st;
    logic st_s1, st_s2, dn_s1, dn_s2;
    logic req_n, clk, fl;
    logic [3:0] div;
    logic [CW-1:0] cnt, bt;
    logic [2:0] ph;
    logic [31:0] data;
    logic ack, busy, restart, fin;
  } pclr_hq_t;

  // Values after reset: status and done driven low, request idle high
  localparam pclr_dq_t DEV_RST = '{st: D_POR, st_oe_n: 1'b0, done_oe_n: 1'b0, init_oe_n: 1'b1, default: '0};
  localparam pclr_hq_t HOST_RST = '{st: H_IDLE, req_n: 1'b1, default: '0};

  // Clocks per word minus one
  function automatic logic [2:0] ratio_m1(input logic [1:0] w, input logic cmp, input logic sec);
    if (!cmp && !sec) begin
      return 3'h0;
    end else if (w == W32) begin
      return cmp ? 3'(RATIO_CMP32 - 1) : 3'(RATIO_SEC32 - 1);
    end
    return 3'(RATIO_NARROW - 1);
  endfunction

  // Keep only the lanes the width uses
  function automatic logic [31:0] bus_mask(input logic [1:0] w, input logic [31:0] v);
    case (w)
      W8: return {24'h000000, v[7:0]};
      W16: return {16'h0000, v[15:0]};
      default: return v;
    endcase
  endfunction

endpackage

// ---- rtl/pclr_if.sv ----
// Link between the config host and the loading device.
// Resolves the open-drain status, done and init lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
interface pclr_if;
  // Host driven
  logic cfg_req_n;
  logic cfg_clock;
  logic [31:0] data;
  // Device open-drain drivers
  logic st_out, st_oe_n;
  logic done_out, done_oe_n;
  logic init_out, init_oe_n;
  // Resolved wire levels
  logic status_n, load_done, init_done;

  // Pulled high unless the device pulls low
  assign status_n = st_oe_n ? 1'b1 : st_out;
  assign load_done = done_oe_n ? 1'b1 : done_out;
  assign init_done = init_oe_n ? 1'b1 : init_out;

  modport dev (
    input cfg_req_n, cfg_clock, data, status_n,
    output st_out, st_oe_n, done_out, done_oe_n, init_out, init_oe_n
  );
  modport host (
    output cfg_req_n, cfg_clock, data,
    input status_n, load_done, init_done
  );
endinterface
`default_nettype wire

// ---- rtl/pclr_host.sv ----
// Host end: pulses the request, waits on status, then clocks the image out.
// Assumes the user presents the next word on word_in whenever word_ack pulses.
`timescale 1ns/1ps
`default_nettype none
module pclr_host
  import pclr_pkg::*;
(
  // System
  input wire logic sys_clk,
  input wire logic reset,
  // Link
  pclr_if.host lnk,
  // Job setup, held while busy
  input wire logic start,
  input wire logic [1:0] scheme_select,
  input wire logic cmp_en,
  input wire logic sec_en,
  input wire logic [CW-1:0] beats,
  // Word source
  input wire logic [31:0] word_in,
  output logic word_ack,
  // Job status
  output logic busy,
  output logic restart,
  output logic fin
);

  // Registered state and its next value
  pclr_hq_t q_q;
  pclr_hq_t q_d;
  // Link clock edges made this cycle
  logic rise;
  logic fall;

  // Next state
  always_comb begin
    q_d = q_q;
    // Status and done come from pins
    q_d.st_s1 = lnk.status_n;
    q_d.st_s2 = q_q.st_s1;
    q_d.dn_s1 = lnk.load_done;
    q_d.dn_s2 = q_q.dn_s1;
    q_d.ack = 1'b0;
    q_d.restart = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    // Divider runs only while sending and in the tail
    if (q_q.st == H_SEND || q_q.st == H_TAIL) begin
      q_d.div = q_q.div + 4'h1;
      if (q_q.div == 4'(CK_HALF_CYC - 1)) begin
        q_d.div = 4'h0;
        q_d.clk = ~q_q.clk;
        rise = ~q_q.clk;
        fall = q_q.clk;
      end
    end

    case (q_q.st)
      // Waiting for a job
      H_IDLE: begin
        if (start) begin
          q_d.st = H_PULSE;
          q_d.req_n = 1'b0;
          q_d.cnt = '0;
          q_d.busy = 1'b1;
          q_d.fin = 1'b0;
        end
      end
      // Request low pulse
      H_PULSE: begin
        q_d.cnt = q_q.cnt + 1'b1;
        if (q_q.cnt == CW'(CFG_CYC - 1)) begin
          q_d.req_n = 1'b1; // [RULE10]
          q_d.st = H_WREL;
        end
      end
      // Status is watched, so the long blind wait is not needed
      H_WREL: begin
        if (q_q.st_s2) begin
          q_d.st = H_GAP;
          q_d.cnt = '0;
        end
      end
      // Gap from status high to first rising edge
      H_GAP: begin
        q_d.cnt = q_q.cnt + 1'b1;
        if (q_q.cnt == CW'(ST2CK_CYC - 1)) begin
          q_d.st = H_SEND; // [RULE14]
          q_d.data = bus_mask(scheme_select, word_in); // [RULE19]
          q_d.ack = 1'b1;
          q_d.bt = '0;
          q_d.ph = '0;
          q_d.div = '0;
          q_d.clk = 1'b0;
        end
      end
      // Clocking words, each held for ratio periods
      H_SEND: begin
        if (rise) begin
          if (q_q.ph == 3'h0) begin
            q_d.bt = q_q.bt + 1'b1;
            q_d.ph = ratio_m1(scheme_select, cmp_en, sec_en); // [RULE21] [RULE20] [RULE15]
          end else begin
            q_d.ph = q_q.ph - 3'h1;
          end
        end
        if (fall && q_q.ph == 3'h0) begin
          if (q_q.bt != beats) begin
            // New word set up in the low half, before the next rise
            q_d.data = bus_mask(scheme_select, word_in); // [RULE4]
            q_d.ack = 1'b1;
          end else begin
            // All beats and their spare clocks given
            q_d.st = H_TAIL; // [RULE5] [RULE22]
            q_d.fl = 1'b0;
          end
        end
      end
      // Keep clocking until done, then two more falls
      H_TAIL: begin
        if (fall && q_q.dn_s2) begin
          q_d.fl = 1'b1;
          if (q_q.fl) begin
            // Clock left low, never floating
            q_d.st = H_IDLE; // [RULE6]
            q_d.busy = 1'b0;
            q_d.fin = 1'b1;
          end
        end
      end
      // Unused codes fall back to reset
      default: begin
        q_d = HOST_RST;
      end
    endcase

    // Status dropping mid-load is an error: pulse the request again
    if ((q_q.st == H_SEND || q_q.st == H_TAIL) && !q_q.st_s2) begin
      q_d.st = H_PULSE; // [RULE23]
      q_d.req_n = 1'b0;
      q_d.cnt = '0;
      q_d.clk = 1'b0;
      q_d.restart = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q_q <= HOST_RST;
    end else begin
      q_q <= q_d;
    end
  end

  // Link pins, all from flops
  assign lnk.cfg_req_n = q_q.req_n;
  assign lnk.cfg_clock = q_q.clk;
  assign lnk.data = q_q.data;
  // User side
  assign word_ack = q_q.ack;
  assign busy = q_q.busy;
  assign restart = q_q.restart;
  assign fin = q_q.fin;

endmodule
`default_nettype wire

// ---- dv/pclr_chk.sv ----
// Checker on the resolved link pins between host and device ends.
// Assumes one sys_clk domain and instantiation beside pclr_if.
`timescale 1ns/1ps
`default_nettype none
module pclr_chk
  import pclr_pkg::*;
#(
  // Shortened status low time of the device
  parameter int ST_MIN_CYC = 50
) (
  // System
  input wire logic sys_clk,
  input wire logic reset,
  // Host pins
  input wire logic cfg_req_n,
  input wire logic cfg_clock,
  input wire logic [31:0] data,
  // Resolved device pins
  input wire logic status_n,
  input wire logic load_done,
  input wire logic init_done
);
  // Answer bound of 600 ns in clocks
  localparam int ANS_MAX = CF2CD_CYC;
  // Release bound; sync slack on top of the status time
  localparam int REL_MAX = ST_MIN_CYC + 10;
  // Request low, status low and status high widths
  logic [15:0] rlo_q, slo_q, shi_q;
  // A request fell since reset, so status width applies
  logic seen_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Saturating width counters, never wrap on long idles
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rlo_q <= '0;
      slo_q <= '0;
      shi_q <= '0;
      seen_q <= 1'b0;
    end else begin
      rlo_q <= cfg_req_n ? '0 : rlo_q + {15'h0000, ~&rlo_q};
      slo_q <= status_n ? '0 : slo_q + {15'h0000, ~&slo_q};
      shi_q <= !status_n ? '0 : shi_q + {15'h0000, ~&shi_q};
      seen_q <= seen_q | $fell(cfg_req_n);
    end
  end

  // A pin pulled low within the answer time
  sequence s_low_soon(sig);
    ##[1:ANS_MAX] !sig;
  endsequence
  // One link clock fall soon
  sequence s_fall_soon;
    ##[1:20] $fell(cfg_clock);
  endsequence
  // Two falls in a row after done
  sequence s_two_falls;
    s_fall_soon ##0 s_fall_soon;
  endsequence

  a_done_fast: assert property ($fell(cfg_req_n) |-> s_low_soon(load_done))
    else $error("done not low after request");
  a_status_fast: assert property ($fell(cfg_req_n) |-> s_low_soon(status_n))
    else $error("status not low after request");
  a_done_hold: assert property (!status_n |-> !load_done)
    else $error("done high while status low");
  a_status_width: assert property ($rose(status_n) && seen_q |-> slo_q >= ST_MIN_CYC)
    else $error("status low too short");
  a_status_release: assert property ($rose(cfg_req_n) |-> ##[1:REL_MAX] status_n)
    else $error("status not released");
  a_req_width: assert property ($rose(cfg_req_n) |-> rlo_q >= CFG_CYC)
    else $error("request pulse too short");
  a_clock_gap: assert property ($rose(cfg_clock) |-> shi_q >= ST2CK_CYC)
    else $error("clock too soon after status");
  a_two_falls: assert property ($rose(load_done) |-> s_two_falls)
    else $error("no two falls after done");
  a_init_start: assert property ($fell(init_done) |-> status_n && !load_done)
    else $error("init pin fell outside load");
  a_data_edge: assert property ($changed(data) |-> !cfg_clock)
    else $error("data moved while clock high");
endmodule
`default_nettype wire

// ---- dv/pclr_tb.sv ----
// Bench joining host and device ends over one pclr_if.
// Assumes shared sys_clk; beats are matched in order through a queue.
`timescale 1ns/1ps
`default_nettype none
module parallel_config_load_ratio_tb_top;
  import pclr_pkg::*;
  // Shortened device waits
  localparam int ST_MIN = 50;
  localparam int POR = 20;
  localparam int INIT = 40;
  localparam int UCKN = 10;
  // Clocks and reset
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic uck = 1'b0;
  // Host job setup
  logic start = 1'b0;
  logic [1:0] sel = W32;
  logic cmp = 1'b0;
  logic sec = 1'b0;
  logic [CW-1:0] beats = 20'h00003;
  logic [31:0] word_in = 32'h00000000;
  // Design outputs
  logic word_ack, busy, restart, fin, word_valid, user_mode;
  logic [31:0] word_out;
  // Image, notes and counters
  logic [31:0] img [8];
  logic [31:0] expq [$];
  int n_errors = 0;
  int cmp_count = 0;
  int widx = 0;
  int nval = 0;
  int gap = 0;
  // Init pin seen low between done and user mode
  logic ilow = 1'b0;
  int i, t;

  pclr_if pl_if();
  pclr_dev #(.POR_CYC(POR), .ST_MIN_CYC(ST_MIN), .CD2UM_CYC(INIT), .UCK_INIT_CYC(UCKN)) pclr_dev_inst (
    .sys_clk(sys_clk), .reset(reset), .lnk(pl_if), .user_init_clock(uck), .scheme_select(sel),
    .img_beats(beats), .word_out(word_out), .word_valid(word_valid), .user_mode(user_mode));
  pclr_host pclr_host_inst (
    .sys_clk(sys_clk), .reset(reset), .lnk(pl_if), .start(start), .scheme_select(sel), .cmp_en(cmp),
    .sec_en(sec), .beats(beats), .word_in(word_in), .word_ack(word_ack), .busy(busy),
    .restart(restart), .fin(fin));
  pclr_chk #(.ST_MIN_CYC(ST_MIN)) pclr_chk_inst (
    .sys_clk(sys_clk), .reset(reset), .cfg_req_n(pl_if.cfg_req_n), .cfg_clock(pl_if.cfg_clock),
    .data(pl_if.data), .status_n(pl_if.status_n), .load_done(pl_if.load_done),
    .init_done(pl_if.init_done));

  // 50 MHz system clock
  initial forever #10 sys_clk = ~sys_clk;
  // User init clock, 60 ns, unrelated in phase
  // Offset so its edges never meet a sys_clk edge
  initial begin
    #5;
    forever #30 uck = ~uck;
  end

  // One comparison, reported at once
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  // Single closing point of the run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A bound ran out; counts as a mismatch
  task automatic hung(input string nm);
    n_errors++;
    $display("unexpected %s exp end got timeout", nm);
    report_and_stop();
  endtask

  // Lanes the width actually carries
  function automatic logic [31:0] lanes(input logic [1:0] w, input logic [31:0] v);
    return (w == W8) ? {24'h000000, v[7:0]} : (w == W16) ? {16'h0000, v[15:0]} : v;
  endfunction

  // Next word on each ack; note what the device must receive
  always @(posedge sys_clk) begin
    if (word_ack === 1'b1) begin
      expq.push_back(lanes(sel, img[widx]));
      widx = widx + 1;
      word_in <= img[widx];
    end
  end

  // Oldest note against each received beat; empty queue forces a miss
  always @(posedge sys_clk) begin
    if (word_valid === 1'b1) begin
      nval++;
      chk("word", (expq.size() > 0) ? expq.pop_front() : ~word_out, word_out);
    end
  end

  // Cycles from done high until user mode
  always @(posedge sys_clk) begin
    if (pl_if.load_done !== 1'b1) begin
      gap <= 0;
      ilow <= 1'b0;
    end else if (user_mode !== 1'b1) begin
      gap <= gap + 1;
      ilow <= ilow | (pl_if.init_done === 1'b0);
    end
  end

  // Reset, then the power-on hold of status
  task automatic do_reset();
    reset <= 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk("por status", 32'h0, {31'h0, pl_if.status_n});
    chk("por done", 32'h0, {31'h0, pl_if.load_done});
    for (t = 0; t < 500 && pl_if.status_n !== 1'b1; t++) @(posedge sys_clk);
    if (t == 500) hung("por");
    chk("por length", 32'h1, 32'(t >= POR - 2));
  endtask

  // One whole load: width, compress, security, init pin, user clock, beats
  task automatic run(input logic [1:0] w, input logic c, input logic s, input logic ip, input logic uk,
                     input int nb);
    sel <= w;
    cmp <= c;
    sec <= s;
    beats <= CW'(nb);
    for (i = 0; i < 8; i++) img[i] = $urandom();
    img[0] = {img[0][31:4], uk, ip, s, c};
    widx = 0;
    nval = 0;
    word_in <= img[0];
    @(posedge sys_clk);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (t = 0; t < 40 && pl_if.load_done !== 1'b0; t++) @(posedge sys_clk);
    chk("done fall", 32'h1, 32'(t <= CF2CD_CYC));
    for (t = 0; t < 20000 && !(fin === 1'b1 && user_mode === 1'b1); t++) @(posedge sys_clk);
    if (t == 20000) hung("load");
    chk("beats", 32'(nb), 32'(nval));
    chk("left", 32'h0, 32'(expq.size()));
    chk("pins", 32'h7, {29'h0, pl_if.cfg_req_n, pl_if.status_n, pl_if.load_done});
    chk("init pin", 32'h1, {31'h0, pl_if.init_done});
    chk("init low", {31'h0, ip}, {31'h0, ilow});
    chk("idle", 32'h0, {30'h0, busy, restart});
    if (uk) begin
      chk("uck gap", 32'h1, 32'(gap >= CD2CU_CYC + 3 * (UCKN - 1)));
    end else begin
      chk("init gap", 32'h1, 32'(gap >= INIT && gap <= INIT * 437 / 175));
    end
    $display("test w%0d c%0d s%0d ended, mismatches %0d", w, c, s, n_errors);
  endtask

  // Every ratio and width, a second reset in mid-run
  initial begin
    void'($urandom(80));
    do_reset();
    run(W32, 1'b1, 1'b0, 1'b1, 1'b0, 3);
    run(W32, 1'b0, 1'b1, 1'b0, 1'b1, 4);
    do_reset();
    run(W8, 1'b1, 1'b1, 1'b1, 1'b0, 5);
    run(W16, 1'b0, 1'b1, 1'b1, 1'b1, 2);
    run(W32, 1'b1, 1'b1, 1'b0, 1'b0, 6);
    run(W16, 1'b0, 1'b0, 1'b0, 1'b0, 3);
    report_and_stop();
  end
endmodule
`default_nettype wire
